// ==== rtl/ram_defs.vh ====
// register addresses, field positions and widths of the alarm match block
// assumes a 4-bit internal register address from the serial front end
`ifndef RAM_DEFS_VH
`define RAM_DEFS_VH

`define RAM_ADDR_W          4
`define RAM_ADDR_WALM_MIN   4'h8
`define RAM_ADDR_WALM_HOUR  4'h9
`define RAM_ADDR_WALM_WDAY  4'hA
`define RAM_ADDR_DALM_MIN   4'hB
`define RAM_ADDR_DALM_HOUR  4'hC

`define RAM_MIN_W           7
`define RAM_HOUR_W          6
`define RAM_WDAY_W          3
`define RAM_WDAY_EN_W       7
`define RAM_HOUR_PM_BIT     5
`define RAM_WDAY_UNUSED     3'h7
`define RAM_RDATA_ZERO      8'h00

`endif

// ==== rtl/ram_alarm_cmp.v ====
// alarm time comparator for one alarm channel
// assumes time and alarm fields share the same bcd and hour-mode encoding
`timescale 1ns/1ps
`default_nettype none
`include "ram_defs.vh"

module ram_alarm_cmp #(
  parameter USE_WDAY = 1
) (
  input  wire [`RAM_MIN_W-1:0]     i_cur_min,
  input  wire [`RAM_HOUR_W-1:0]    i_cur_hour,
  input  wire [`RAM_WDAY_W-1:0]    i_cur_wday,
  input  wire [`RAM_MIN_W-1:0]     i_alm_min,
  input  wire [`RAM_HOUR_W-1:0]    i_alm_hour,
  input  wire [`RAM_WDAY_EN_W-1:0] i_alm_wday_en,
  output wire                      o_match
);

  // one-hot weekday decode; code 111 hits no enable bit
  function [`RAM_WDAY_EN_W-1:0] ram_wday_dec;
    input [`RAM_WDAY_W-1:0] code;
    integer n;
    begin
      ram_wday_dec = {`RAM_WDAY_EN_W{1'b0}};
      for (n = 0; n < `RAM_WDAY_EN_W; n = n + 1) begin
        if (code == n[`RAM_WDAY_W-1:0]) begin
          ram_wday_dec[n] = 1'b1;
        end
      end
    end
  endfunction

  wire time_eq;
  wire wday_ok;

  // bit 5 compares as pm flag or tens-two alike, raw encoding matches
  assign time_eq = (i_cur_min == i_alm_min) && (i_cur_hour == i_alm_hour);

  generate
    if (USE_WDAY != 0) begin : g_wday
      // all enables zero suppresses the alarm; code 111 never fires
      assign wday_ok = |(ram_wday_dec(i_cur_wday) & i_alm_wday_en);
    end else begin : g_nowday
      assign wday_ok = 1'b1;
    end
  endgenerate

  assign o_match = time_eq & wday_ok;

endmodule // ram_alarm_cmp

`default_nettype wire

// ==== rtl/ram_alarm_regs.v ====
// alarm value registers and minute-match event generation
// assumes a register front end supplying address, write strobe and data,
// and time counters with a one-cycle pulse when the minute counter updates
//
// Overview of operation
// - the weekly weekday register holds seven enables in bits 6..0, one per weekday code 0..6, bit 7 reads zero.
// - with all seven weekday enables zero the weekly alarm never fires.
// - weekly alarm hour bit 5 is the pm flag in 12-hour mode and tens-two in 24-hour mode.
// - daily alarm hour bit 5 is the pm flag in 12-hour mode and tens-two in 24-hour mode.
// - in 12-hour mode midnight is hour 12 and noon is 32, later pm hours are flag plus bcd hour.
// - an alarm fires only when minute and hour match, and for weekly also an enabled weekday.
// - daily minute holds bits 6..0 with bit 7 zero, daily hour holds bits 5..0 with bits 7..6 zero.
// - the weekday enable register sits at address a, its top bit is dropped on write and reads zero.
// - alarm value bits are undefined after power-up, only unused bits read zero.
// - weekday code steps 0..6 and wraps, code 7 matches no enable.
`timescale 1ns/1ps
`default_nettype none
`include "ram_defs.vh"

module ram_alarm_regs (
  input  wire                      i_mclk,
  input  wire                      i_nrst,
  input  wire [`RAM_ADDR_W-1:0]    i_addr,
  input  wire                      i_wr,
  input  wire [7:0]                i_wdata,
  input  wire [`RAM_MIN_W-1:0]     i_cur_min,
  input  wire [`RAM_HOUR_W-1:0]    i_cur_hour,
  input  wire [`RAM_WDAY_W-1:0]    i_cur_wday,
  input  wire                      i_min_tick,
  output reg  [7:0]                o_rdata,
  output reg                       o_weekly_alarm,
  output reg                       o_daily_alarm
);

  // alarm values carry no reset: contents undefined after power-up
  reg [`RAM_MIN_W-1:0]     walm_min_r;
  reg [`RAM_HOUR_W-1:0]    walm_hour_r;
  reg [`RAM_WDAY_EN_W-1:0] walm_wday_en_r;
  reg [`RAM_MIN_W-1:0]     dalm_min_r;
  reg [`RAM_HOUR_W-1:0]    dalm_hour_r;

  reg [7:0]                rdata_nxt;
  wire                     weekly_match;
  wire                     daily_match;

  // register writes; unused top bits are dropped
  always @(posedge i_mclk) begin
    if (i_wr) begin
      case (i_addr)
        `RAM_ADDR_WALM_MIN: begin
          walm_min_r <= i_wdata[`RAM_MIN_W-1:0];
        end
        `RAM_ADDR_WALM_HOUR: begin
          walm_hour_r <= i_wdata[`RAM_HOUR_W-1:0];
        end
        `RAM_ADDR_WALM_WDAY: begin
          walm_wday_en_r <= i_wdata[`RAM_WDAY_EN_W-1:0];
        end
        `RAM_ADDR_DALM_MIN: begin
          dalm_min_r <= i_wdata[`RAM_MIN_W-1:0];
        end
        `RAM_ADDR_DALM_HOUR: begin
          dalm_hour_r <= i_wdata[`RAM_HOUR_W-1:0];
        end
        default: begin
        end
      endcase
    end
  end

  // read mux; unused bits and unmapped addresses read zero
  always @* begin
    rdata_nxt = `RAM_RDATA_ZERO;
    case (i_addr)
      `RAM_ADDR_WALM_MIN: begin
        rdata_nxt = {1'b0, walm_min_r};
      end
      `RAM_ADDR_WALM_HOUR: begin
        rdata_nxt = {2'b00, walm_hour_r};
      end
      `RAM_ADDR_WALM_WDAY: begin
        rdata_nxt = {1'b0, walm_wday_en_r};
      end
      `RAM_ADDR_DALM_MIN: begin
        rdata_nxt = {1'b0, dalm_min_r};
      end
      `RAM_ADDR_DALM_HOUR: begin
        rdata_nxt = {2'b00, dalm_hour_r};
      end
      default: begin
        rdata_nxt = `RAM_RDATA_ZERO;
      end
    endcase
  end

  ram_alarm_cmp #(
    .USE_WDAY (1)
  ) u_weekly_cmp (
    .i_cur_min     (i_cur_min),
    .i_cur_hour    (i_cur_hour),
    .i_cur_wday    (i_cur_wday),
    .i_alm_min     (walm_min_r),
    .i_alm_hour    (walm_hour_r),
    .i_alm_wday_en (walm_wday_en_r),
    .o_match       (weekly_match)
  );

  ram_alarm_cmp #(
    .USE_WDAY (0)
  ) u_daily_cmp (
    .i_cur_min     (i_cur_min),
    .i_cur_hour    (i_cur_hour),
    .i_cur_wday    (i_cur_wday),
    .i_alm_min     (dalm_min_r),
    .i_alm_hour    (dalm_hour_r),
    .i_alm_wday_en ({`RAM_WDAY_EN_W{1'b0}}),
    .o_match       (daily_match)
  );

  // one-cycle events only on a minute update that matches
  always @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_rdata        <= `RAM_RDATA_ZERO;
      o_weekly_alarm <= 1'b0;
      o_daily_alarm  <= 1'b0;
    end else begin
      o_rdata        <= rdata_nxt;
      o_weekly_alarm <= i_min_tick & weekly_match;
      o_daily_alarm  <= i_min_tick & daily_match;
    end
  end

endmodule // ram_alarm_regs

`default_nettype wire

// ==== bench/ram_alarm_assertions.sv ====
// port checker for the alarm register block
// assumes it is bound onto ram_alarm_regs
`timescale 1ns/1ps
`default_nettype none
module ram_alarm_assertions (
  input wire logic       i_mclk,
  input wire logic       i_nrst,
  input wire logic [3:0] i_addr,
  input wire logic       i_wr,
  input wire logic [7:0] i_wdata,
  input wire logic [6:0] i_cur_min,
  input wire logic [5:0] i_cur_hour,
  input wire logic [2:0] i_cur_wday,
  input wire logic       i_min_tick,
  input wire logic [7:0] o_rdata,
  input wire logic       o_weekly_alarm,
  input wire logic       o_daily_alarm
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);
  sequence wr_to(a);
    i_wr && i_addr == a ##1 !i_wr && i_addr == a;
  endsequence
  a_wday_echo: assert property (wr_to(4'ha) |=>
    o_rdata == {1'b0, $past(i_wdata[6:0], 2)}) else $error("weekday readback");
  a_dhour_echo: assert property (wr_to(4'hc) |=>
    o_rdata == {2'b00, $past(i_wdata[5:0], 2)}) else $error("daily hour readback");
  a_whour_echo: assert property (wr_to(4'h9) |=>
    o_rdata == {2'b00, $past(i_wdata[5:0], 2)}) else $error("weekly hour readback");
  a_dmin_echo: assert property (wr_to(4'hb) |=>
    o_rdata == {1'b0, $past(i_wdata[6:0], 2)}) else $error("daily minute readback");
  a_unmapped_zero: assert property (i_addr < 4'h8 || i_addr > 4'hc |=>
    o_rdata == 8'h00) else $error("unmapped read not zero");
  a_tick_cause: assert property (o_daily_alarm || o_weekly_alarm |->
    $past(i_min_tick)) else $error("alarm without minute tick");
  a_code7_none: assert property (i_min_tick && i_cur_wday == 3'h7 |=>
    !o_weekly_alarm) else $error("weekly alarm on code 7");
  a_weekly_once: assert property (o_weekly_alarm && !i_min_tick |=>
    !o_weekly_alarm) else $error("weekly alarm repeated");
endmodule // ram_alarm_assertions
bind ram_alarm_regs ram_alarm_assertions ram_alarm_assertions_inst (.*);
`default_nettype wire

// ==== bench/ram_host_model.sv ====
// host software model driving the register port
// assumes the bench wants changes at the falling edge
`timescale 1ns/1ps
`default_nettype none
module ram_host_model (
  input  wire logic       i_mclk,
  output var  logic [3:0] o_addr = 4'h0,
  output var  logic       o_wr   = 1'b0,
  output var  logic [7:0] o_wdata = 8'h00
);
  // one-cycle write of the given byte with no bcd check, day meaning set by software
  task put(input logic [3:0] a, input logic [7:0] d);
    @(negedge i_mclk);
    {o_addr, o_wr, o_wdata} = {a, 1'b1, d};
    @(negedge i_mclk);
    {o_wr, o_wdata} = {1'b0, ~d};
  endtask
  task point(input logic [3:0] a);
    @(negedge i_mclk);
    o_addr = a;
  endtask
endmodule // ram_host_model
`default_nettype wire

// ==== bench/ram_alarm_regs_tb_top.sv ====
// self-checking bench for the alarm register block
// assumes the host model owns the register port
`timescale 1ns/1ps
`default_nettype none
module ram_alarm_regs_tb_top;
  logic       clk = 1'b0, nrst = 1'b0, tick = 1'b0, wr, wa, da;
  logic [6:0] cmin = 7'h00;
  logic [5:0] chr = 6'h00;
  logic [2:0] cwd = 3'h0;
  logic [3:0] addr;
  logic [7:0] wd, rdata, d;
  logic [1:0] q[$];
  int         miscompares = 0, checks = 0;
  integer     seed = 32'h769f;
  always #10 clk = ~clk;
  ram_host_model h (.i_mclk(clk), .o_addr(addr), .o_wr(wr), .o_wdata(wd));
  ram_alarm_regs ram_alarm_regs_inst (.i_mclk(clk), .i_nrst(nrst), .i_addr(addr), .i_wr(wr),
    .i_wdata(wd), .i_cur_min(cmin), .i_cur_hour(chr), .i_cur_wday(cwd), .i_min_tick(tick),
    .o_rdata(rdata), .o_weekly_alarm(wa), .o_daily_alarm(da));
  task cmp_rdata(input logic [7:0] e, input logic [7:0] s);
    checks++;
    if (s !== e) begin
      miscompares++;
      $display("[ERR] o_rdata expected %h seen %h", e, s);
    end
  endtask
  task cmp_alarm(input logic [1:0] e, input logic [1:0] s);
    checks++;
    if (s !== e) begin
      miscompares++;
      $display("[ERR] alarms expected %b seen %b", e, s);
    end
  endtask
  task rd(input logic [3:0] a, input logic [7:0] e);
    h.point(a);
    @(negedge clk);
    cmp_rdata(e, rdata);
  endtask
  task tk(input logic [6:0] m, input logic [5:0] hr, input logic [2:0] w, input logic [1:0] e);
    @(negedge clk);
    {cmin, chr, cwd, tick} = {m, hr, w, 1'b1};
    if (e !== 2'b00) q.push_back(e);
    @(negedge clk);
    tick = 1'b0;
    repeat (2) @(negedge clk);
  endtask
  // outputs are looked at on the falling edge, settled and clear of reset
  always @(negedge clk) if (wa !== 1'b0 || da !== 1'b0)
    cmp_alarm(q.size() ? q.pop_front() : 2'b00, {wa, da});
  task report_and_stop;
    if (q.size() != 0) miscompares++;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (4) @(negedge clk);
    nrst = 1'b1;
    rd(4'h3, 8'h00);
    repeat (4) begin
      d = $random(seed);
      h.put(4'ha, d);
      rd(4'ha, {1'b0, d[6:0]});
    end
    h.put(4'hb, 8'hb0);
    rd(4'hb, 8'h30);
    h.put(4'hc, 8'hf2);
    rd(4'hc, 8'h32);
    h.put(4'h8, 8'h30);
    h.put(4'h9, 8'hf2);
    rd(4'h9, 8'h32);
    h.put(4'ha, 8'h02);
    tk(7'h30, 6'h32, 3'h1, 2'b11);
    tk(7'h30, 6'h32, 3'h0, 2'b01);
    tk(7'h30, 6'h32, 3'h7, 2'b01);
    tk(7'h30, 6'h12, 3'h1, 2'b00);
    tk(7'h31, 6'h32, 3'h1, 2'b00);
    h.put(4'ha, 8'h00);
    tk(7'h30, 6'h32, 3'h1, 2'b01);
    report_and_stop;
  end
  initial begin
    repeat (5000) @(posedge clk);
    miscompares++;
    report_and_stop;
  end
endmodule // ram_alarm_regs_tb_top
`default_nettype wire
